// ===== design/standard_timer.sv
/*
  standard timer: ten-bit counter, period and compare A comparators,
  output pin logic for compare and pulse modes, capture mode, axi4-lite regs.
  assumes high_clock and timebase_clock enables, the external count pin
  and the capture pin are synchronous single-bit levels of aclk.
*/
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module standard_timer
  import stm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic high_clock_tick,
  input wire logic timebase_clock_tick,
  input wire logic ext_count_clock_pin,
  input wire logic capture_pin,
  output logic timer_out_pin_0,
  output logic timer_out_pin_1,
  output logic match_a_flag,
  output logic match_p_flag,
  output logic capture_event
);

  logic [7:0] ctrl0_ff, ctrl1_ff, cmpa_lo_ff;
  logic [1:0] cmpa_hi_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic on_d_ff, out_ff, single_done_ff;
  logic [5:0] pre_ff;
  logic [2:0] ext_sync_ff;
  logic [2:0] cap_sync_ff;
  logic [CNT_W-1:0] cap_ff;
  logic aw_ff, w_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;

  wire timer_on = ctrl0_ff[C0_ON];
  wire counter_hold = ctrl0_ff[C0_HOLD];
  wire [2:0] clock_select = ctrl0_ff[C0_CKS_HI:C0_CKS_LO];
  wire [2:0] compare_p_value = ctrl0_ff[C0_RP_HI:0];
  wire [1:0] op_mode_select = ctrl1_ff[C1_MODE_HI:C1_MODE_LO];
  wire [1:0] pin_function_select = ctrl1_ff[C1_IO_HI:C1_IO_LO];
  wire output_initial_level = ctrl1_ff[C1_OC];
  wire output_invert = ctrl1_ff[C1_POL];
  wire period_duty_swap = ctrl1_ff[C1_DPX];
  wire clear_source_select = ctrl1_ff[C1_CCLR];
  wire [CNT_W-1:0] compare_a_value = {cmpa_hi_ff, cmpa_lo_ff};

  // mode decode shared by the clear, output and capture paths
  function automatic logic in_mode(input logic [1:0] m,
    input logic [1:0] want);
    in_mode = m == want;
  endfunction

  // count clock enable per source
  wire ext_rise = ext_sync_ff[1] & ~ext_sync_ff[2];
  wire ext_fall = ~ext_sync_ff[1] & ext_sync_ff[2];
  logic tick;
  always_comb begin
    case (clock_select)
      CKS_SYS_DIV4: tick = pre_ff[1:0] == 2'(DIV4 - 1);
      CKS_SYS: tick = 1'b1;
      CKS_HIGH_DIV16: tick = high_clock_tick && pre_ff[3:0] == 4'(DIV16 - 1);
      CKS_HIGH_DIV64: tick = high_clock_tick && pre_ff == 6'(DIV64 - 1);
      CKS_TIMEBASE: tick = timebase_clock_tick;
      CKS_EXT_RISE: tick = ext_rise;
      CKS_EXT_FALL: tick = ext_fall;
      default: tick = 1'b0;
    endcase
  end
  wire run = timer_on && !counter_hold;
  wire adv = run && tick;
  wire on_rise = timer_on && !on_d_ff;

  // comparators, evaluated on the value the counter is about to reach
  wire [CNT_W-1:0] cnt_inc = cnt_ff + 10'h001;
  wire ovf = adv && cnt_ff == '1;
  wire p_hit = adv && (compare_p_value == 3'h0 ? ovf :
    cnt_inc[CNT_W-1:CNT_W-3] == compare_p_value &&
    cnt_inc[CNT_W-4:0] == '0);
  wire a_hit = adv && cnt_inc == compare_a_value;
  wire is_pulse = in_mode(op_mode_select, MODE_PULSE);
  wire cmp_mode = in_mode(op_mode_select, MODE_COMPARE) ||
    in_mode(op_mode_select, MODE_TIMER);
  // pulse mode: dpx chooses which comparator ends the period
  wire pw_period_hit = period_duty_swap ? a_hit : p_hit;
  wire [CNT_W:0] p_full = (compare_p_value == 3'h0) ? 11'h400 :
    {1'b0, compare_p_value, 7'h00};
  wire [CNT_W:0] duty = period_duty_swap ? p_full : {1'b0, compare_a_value};
  wire [CNT_W:0] period = period_duty_swap ?
    ((compare_a_value == '0) ? 11'h400 : {1'b0, compare_a_value}) : p_full;
  wire pw_active = duty >= period ||
    {1'b0, cnt_ff} < duty;
  wire clr_cnt = is_pulse ? pw_period_hit :
    (cmp_mode ? (clear_source_select ? a_hit : p_hit) : ovf);
  wire [CNT_W-1:0] nxt_cnt = on_rise ? '0 : (!adv ? cnt_ff :
    (clr_cnt ? '0 : cnt_inc));
  wire nxt_a_flag = a_hit;
  wire nxt_p_flag = p_hit && !(cmp_mode && clear_source_select);

  // output level before polarity
  logic nxt_out;
  always_comb begin
    nxt_out = out_ff;
    if (op_mode_select == MODE_COMPARE) begin
      if (on_rise)
        nxt_out = output_initial_level;
      else if (a_hit) begin
        case (pin_function_select)
          IO_01: nxt_out = 1'b0;
          IO_10: nxt_out = 1'b1;
          IO_11: nxt_out = ~out_ff;
          default: nxt_out = out_ff;
        endcase
      end
    end else if (is_pulse) begin
      case (pin_function_select)
        IO_00: nxt_out = ~output_initial_level;
        IO_01: nxt_out = output_initial_level;
        IO_10: nxt_out = pw_active ? output_initial_level :
          ~output_initial_level;
        IO_11: nxt_out = (timer_on && !single_done_ff && pw_active) ?
          output_initial_level : ~output_initial_level;
        default: nxt_out = out_ff;
      endcase
    end else begin
      nxt_out = 1'b0;
    end
  end
  // timer mode leaves the pin idle low regardless of polarity
  wire pin_level = (op_mode_select == MODE_TIMER) ? 1'b0 :
    nxt_out ^ output_invert;
  wire nxt_single_done = on_rise ? 1'b0 :
    (single_done_ff | (is_pulse && pw_period_hit));

  // capture edge selection
  wire cap_r = cap_sync_ff[1] & ~cap_sync_ff[2];
  wire cap_f = ~cap_sync_ff[1] & cap_sync_ff[2];
  logic cap_hit;
  always_comb begin
    case (pin_function_select)
      IO_00: cap_hit = cap_r;
      IO_01: cap_hit = cap_f;
      IO_10: cap_hit = cap_r | cap_f;
      default: cap_hit = 1'b0;
    endcase
  end
  wire do_cap = timer_on && in_mode(op_mode_select, MODE_CAPTURE) &&
    cap_hit;

  // the counter itself
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // previous timer_on, for the rising-edge clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on_d_ff <= 1'b0;
    end else begin
      on_d_ff <= timer_on;
    end
  end

  // output level state and single pulse latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_ff <= 1'b0;
      single_done_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
      single_done_ff <= nxt_single_done;
    end
  end

  // prescaler cleared to zero while the timer is off or held, so an off timer draws no toggles
  wire pre_step = clock_select == CKS_SYS_DIV4 || high_clock_tick;
  wire [5:0] nxt_pre = !run ? '0 : (pre_step ? pre_ff + 6'h01 : pre_ff);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= nxt_pre;
    end
  end

  // two flops per pin, the third only feeds the edge detectors
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_sync_ff <= '0;
      cap_sync_ff <= '0;
    end else begin
      ext_sync_ff <= {ext_sync_ff[1:0], ext_count_clock_pin};
      cap_sync_ff <= {cap_sync_ff[1:0], capture_pin};
    end
  end

  // captured count and its event pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_ff <= '0;
      capture_event <= 1'b0;
    end else begin
      cap_ff <= do_cap ? cnt_ff : cap_ff;
      capture_event <= do_cap;
    end
  end

  // match_p_flag pulses one cycle; match_a_flag stays high while compare A of 1 clears the counter each aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
    end else begin
      match_a_flag <= nxt_a_flag;
      match_p_flag <= nxt_p_flag;
    end
  end

  // both pins carry the same level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_out_pin_0 <= 1'b0;
      timer_out_pin_1 <= 1'b0;
    end else begin
      timer_out_pin_0 <= pin_level;
      timer_out_pin_1 <= pin_level;
    end
  end

  // axi4-lite slave: single outstanding write and read
  wire w_go = aw_ff && w_ff && !s_axi_bvalid;
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = a <= OFS_FLAGS && a[1:0] == 2'h0;
  endfunction
  wire wr_ok = mapped(awaddr_ff) && awaddr_ff != OFS_CNT_LO &&
    awaddr_ff != OFS_CNT_HI && awaddr_ff != OFS_FLAGS;
  wire wr_lane = wstrb_ff[0];
  wire [7:0] wb = wdata_ff[7:0];

  logic [31:0] rd_val;
  always_comb begin
    case (s_axi_araddr)
      OFS_CTRL0: rd_val = {24'h0, ctrl0_ff};
      OFS_CTRL1: rd_val = {24'h0, ctrl1_ff};
      OFS_CNT_LO: rd_val = {24'h0, cnt_ff[7:0]};
      OFS_CNT_HI: rd_val = {30'h0, cnt_ff[CNT_W-1:8]};
      OFS_CMPA_LO: rd_val = {24'h0, cmpa_lo_ff};
      OFS_CMPA_HI: rd_val = {30'h0, cmpa_hi_ff};
      OFS_FLAGS: rd_val = {22'h0, cap_ff};
      default: rd_val = 32'h0;
    endcase
  end

  // write address: ready pulses only while no write is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      awaddr_ff <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_ff && !s_axi_awready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (w_go) begin
        aw_ff <= 1'b0;
      end
    end
  end

  // write data, taken independently of the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_ff <= 1'b0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_ff && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (w_go) begin
        w_ff <= 1'b0;
      end
    end
  end

  // write response stands until the master takes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (w_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // registers change only on an accepted, in-map, low-lane write
  wire reg_we = w_go && wr_ok && wr_lane;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0_ff <= CTRL_RESET;
      ctrl1_ff <= CTRL_RESET;
      cmpa_lo_ff <= CTRL_RESET;
      cmpa_hi_ff <= '0;
    end else if (reg_we) begin
      case (awaddr_ff)
        OFS_CTRL0: ctrl0_ff <= wb;
        OFS_CTRL1: ctrl1_ff <= wb;
        OFS_CMPA_LO: cmpa_lo_ff <= wb;
        OFS_CMPA_HI: cmpa_hi_ff <= wb[1:0];
        default: ctrl0_ff <= ctrl0_ff;
      endcase
    end
  end

  // read channel: data sampled at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // standard_timer

// ===== design/stm_pkg.sv
/*
  constants, register map and field layout for the standard timer block.
  assumes an axi4-lite master and a single 100 MHz system clock.
*/
package stm_pkg;
  localparam int CNT_W = 10;
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_CTRL0 = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL1 = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_CNT_LO = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_CNT_HI = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_CMPA_LO = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_CMPA_HI = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 5'h18;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // control 0 fields
  localparam int C0_HOLD = 7;
  localparam int C0_CKS_HI = 6;
  localparam int C0_CKS_LO = 4;
  localparam int C0_ON = 3;
  localparam int C0_RP_HI = 2;
  // control 1 fields
  localparam int C1_MODE_HI = 7;
  localparam int C1_MODE_LO = 6;
  localparam int C1_IO_HI = 5;
  localparam int C1_IO_LO = 4;
  localparam int C1_OC = 3;
  localparam int C1_POL = 2;
  localparam int C1_DPX = 1;
  localparam int C1_CCLR = 0;
  localparam logic [2:0] CKS_SYS_DIV4 = 3'h0;
  localparam logic [2:0] CKS_SYS = 3'h1;
  localparam logic [2:0] CKS_HIGH_DIV16 = 3'h2;
  localparam logic [2:0] CKS_HIGH_DIV64 = 3'h3;
  localparam logic [2:0] CKS_TIMEBASE = 3'h4;
  localparam logic [2:0] CKS_EXT_RISE = 3'h6;
  localparam logic [2:0] CKS_EXT_FALL = 3'h7;
  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PULSE = 2'h2;
  localparam logic [1:0] MODE_TIMER = 2'h3;
  localparam logic [1:0] IO_00 = 2'h0;
  localparam logic [1:0] IO_01 = 2'h1;
  localparam logic [1:0] IO_10 = 2'h2;
  localparam logic [1:0] IO_11 = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int DIV4 = 4;
  localparam int DIV16 = 16;
  localparam int DIV64 = 64;
endpackage

// ===== tb/count_pin_model.sv
/*
  external count pin source.
  assumes the caller starts pulses after a clock edge.
*/
`timescale 1ns/1ps
module count_pin_model (
  input wire logic aclk,
  output logic ext_count_clock_pin
);
  initial ext_count_clock_pin = 1'b0;
  // four cycles high and five low between pulses, well clear of the two-flop sync
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge aclk);
      ext_count_clock_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      ext_count_clock_pin <= 1'b0;
      repeat (4) @(posedge aclk);
    end
  endtask
endmodule // count_pin_model

// ===== tb/standard_timer_props.sv
/*
  assertions on the timer's bus and pin ports.
  assumes one clock domain, aresetn synchronous and active low.
*/
`timescale 1ns/1ps
module standard_timer_props
  import stm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic timer_out_pin_0,
  input wire logic timer_out_pin_1,
  input wire logic match_p_flag
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready
    |-> ##[1:4] s_axi_bvalid) else $error("write not answered");
  rd_answer_a: assert property (ar_taken |-> ##[1:2] s_axi_rvalid)
    else $error("read not answered");
  one_write_a: assert property (s_axi_bvalid |-> !s_axi_awready
    && !s_axi_wready) else $error("write taken while busy");
  one_read_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  ar_cause_a: assert property (s_axi_arready |-> s_axi_arvalid)
    else $error("arready without request");
  pins_same_a: assert property (timer_out_pin_0 == timer_out_pin_1)
    else $error("output pins differ");
  pflag_pulse_a: assert property (match_p_flag |=> !match_p_flag)
    else $error("period flag too long");
  err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("refused read has data");
endmodule // standard_timer_props

bind standard_timer standard_timer_props u_props (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
  .s_axi_rresp, .timer_out_pin_0, .timer_out_pin_1, .match_p_flag);

// ===== tb/standard_timer_test.sv
/*
  self-checking bench for the timer over axi4-lite.
  assumes the checker is bound in and the pin model drives the count pin.
*/
`timescale 1ns/1ps
module standard_timer_test;
  import stm_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, high_clock_tick;
  logic timebase_clock_tick, ext_count_clock_pin, capture_pin;
  logic timer_out_pin_0, timer_out_pin_1, match_a_flag, match_p_flag;
  logic capture_event;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [9:0] c0, c1;
  logic [2:0] rps [3] = '{3'h1, 3'h2, 3'h0};
  int errors = 0, tests_run = 0, pflags = 0, k, n, p0;

  standard_timer u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .high_clock_tick,
    .timebase_clock_tick, .ext_count_clock_pin, .capture_pin,
    .timer_out_pin_0, .timer_out_pin_1, .match_a_flag, .match_p_flag,
    .capture_event);
  count_pin_model u_pin (.aclk, .ext_count_clock_pin);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    high_clock_tick <= ~high_clock_tick;
    timebase_clock_tick <= ~timebase_clock_tick;
    if (match_p_flag === 1'b1) pflags <= pflags + 1;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tmo(input string nm);
    errors++;
    $display("[FAIL] %s exp answer got none", nm);
    test_done;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (i == 64) tmo("write");
    rsp = s_axi_bresp;
  endtask
  task automatic rd(input logic [4:0] a);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (i == 64) tmo("read");
    rv = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  // pair is not latched: only read while stopped or small
  task automatic rdcnt(output logic [9:0] c);
    rd(OFS_CNT_LO);
    c[7:0] = rv[7:0];
    rd(OFS_CNT_HI);
    c[9:8] = rv[1:0];
  endtask
  task automatic gap(input bit a_sel, output int g);
    int i, first;
    first = -1;
    g = -1;
    for (i = 0; i < 2300; i++) begin
      @(posedge aclk);
      if ((a_sel ? match_a_flag : match_p_flag) === 1'b1) begin
        if (first >= 0) begin
          g = i - first;
          break;
        end
        first = i;
      end
    end
    if (g < 0) tmo("flag");
  endtask
  task automatic restart(input logic [7:0] c1v, input logic [7:0] c0v);
    wr(OFS_CTRL0, 8'h00);
    wr(OFS_CTRL1, c1v);
    wr(OFS_CTRL0, c0v);
    repeat (3) @(posedge aclk);
  endtask

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {high_clock_tick, timebase_clock_tick, capture_pin} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_CTRL0);
    chk("ctrl0_rst", 32'h0, rv);
    rd(OFS_CTRL1);
    chk("ctrl1_rst", 32'h0, rv);
    wr(OFS_CMPA_HI, 8'hff);
    rd(OFS_CMPA_HI);
    chk("cmpa_hi", 32'h3, rv);
    wr(OFS_CNT_LO, 8'h55);
    chk("cnt_wr", RESP_SLVERR, rsp);
    rd(5'h1c);
    chk("unmapped", RESP_SLVERR, rsp);
    $display("test registers done");
    wr(OFS_CTRL0, 8'h18);
    wr(OFS_CTRL0, 8'h98);
    rdcnt(c0);
    rdcnt(c1);
    chk("hold", c0, c1);
    wr(OFS_CTRL0, 8'h18);
    rdcnt(c1);
    chk("resume", 1, c1 > c0);
    wr(OFS_CTRL0, 8'h10);
    rdcnt(c0);
    rdcnt(c1);
    chk("off_keep", c0, c1);
    wr(OFS_CTRL0, 8'h58);
    rdcnt(c0);
    chk("on_clear", 0, c0);
    for (k = 0; k < 5; k++) begin
      restart(8'h00, {1'b0, k[2:0], 4'h8});
      repeat (300) @(posedge aclk);
      wr(OFS_CTRL0, {1'b0, k[2:0], 4'h0});
      rdcnt(c0);
      chk("int_clock", 1, c0 != 0);
    end
    for (k = 6; k < 8; k++) begin
      restart(8'h00, {1'b0, k[2:0], 4'h8});
      u_pin.pulse(5);
      rdcnt(c0);
      chk("ext_count", 5, c0);
    end
    $display("test count control done");
    for (k = 0; k < 3; k++) begin
      restart(8'h00, {5'h03, rps[k]});
      gap(1'b0, n);
      chk("period", rps[k] == 0 ? 1024 : 128 * rps[k], n);
    end
    wr(OFS_CMPA_LO, 8'h2c);
    wr(OFS_CMPA_HI, 8'h01);
    restart(8'h21, 8'h19);
    chk("pin_init", 0, timer_out_pin_0);
    p0 = pflags;
    gap(1'b1, n);
    chk("clear_on_a", 300, n);
    chk("no_pflag", p0, pflags);
    repeat (2) @(posedge aclk);
    chk("pin_high", 1, timer_out_pin_0);
    restart(8'h11, 8'h19);
    gap(1'b1, n);
    repeat (2) @(posedge aclk);
    chk("pin_same", 0, timer_out_pin_0);
    restart(8'h25, 8'h19);
    chk("pin_invert", 1, timer_out_pin_0);
    for (k = 0; k < 2; k++) begin
      restart({2'h2, k[1:0], 4'h8}, 8'h19);
      chk("pulse_force", k, timer_out_pin_0);
    end
    restart(8'hc4, 8'h19);
    chk("timer_pin", 0, timer_out_pin_0);
    $display("test compare output done");
    test_done;
  end
endmodule // standard_timer_test
